// file: fci_pkg.sv
// Constants shared by the flash command host and its bus-cycle engine.
// Assumes a byte-wide flash with a 19-bit address and a 20 MHz clock.
`default_nettype none
package fci_pkg;
	// ---------------------------------------------------------------
	// Widths and clock
	// ---------------------------------------------------------------
	localparam int ADDR_W = 19;
	localparam int CLK_NS = 50;
	// ---------------------------------------------------------------
	// Command addresses (low eleven bits) and command bytes
	// ---------------------------------------------------------------
	localparam logic [10:0] ADDR_UNLOCK1 = 11'h555;
	localparam logic [10:0] ADDR_UNLOCK2 = 11'h2aa;
	localparam logic [7:0] DAT_UNLOCK1 = 8'haa;
	localparam logic [7:0] DAT_UNLOCK2 = 8'h55;
	localparam logic [7:0] CMD_RESET = 8'hf0;
	localparam logic [7:0] CMD_AUTOSEL = 8'h90;
	localparam logic [7:0] CMD_PROGRAM = 8'ha0;
	localparam logic [7:0] CMD_BYPASS = 8'h20;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
	localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
	localparam logic [7:0] CMD_BLOCK_ERASE = 8'h30;
	localparam logic [7:0] CMD_SUSPEND = 8'hb0;
	localparam logic [7:0] CMD_RESUME = 8'h30;
	localparam logic [7:0] CMD_BYPASS_EXIT = 8'h00;
	// ---------------------------------------------------------------
	// Timing: figures in microseconds, then counts of clock cycles
	// ---------------------------------------------------------------
	localparam int ABORT_US = 10;
	localparam int SUSPEND_US = 15;
	localparam int BLOCK_WINDOW_US = 50;
	localparam int PROGRAM_MAX_US = 200;
	localparam int ABORT_CYC = (ABORT_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int SUSPEND_CYC = (SUSPEND_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int WINDOW_CYC = (BLOCK_WINDOW_US * 1000) / CLK_NS;
	localparam int PROGRAM_CYC = (PROGRAM_MAX_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int READ_ACCESS_CYC = 3;
	// ---------------------------------------------------------------
	// Host operations and tracked device modes
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		FCI_OP_READ, FCI_OP_RESET1, FCI_OP_RESET3, FCI_OP_AUTOSEL,
		FCI_OP_PROGRAM, FCI_OP_BYPASS, FCI_OP_BYPASS_PROG,
		FCI_OP_BYPASS_RESET, FCI_OP_CHIP_ERASE, FCI_OP_BLOCK_ERASE,
		FCI_OP_BLOCK_ADD, FCI_OP_SUSPEND, FCI_OP_RESUME
	} fci_op_t;
	typedef enum logic [1:0] {
		FCI_MODE_READ, FCI_MODE_AUTOSEL, FCI_MODE_BYPASS
	} fci_mode_t;
endpackage
`default_nettype wire

// file: fci_bus_cycle.sv
// One bus read or bus write on the flash pins.
// Assumes the caller pulses start only while the engine is idle.
`default_nettype none
module fci_bus_cycle #(
	parameter int ACCESS_CYC = fci_pkg::READ_ACCESS_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic is_read,
	input wire logic [18:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] dq_in,
	output logic done,
	output logic [7:0] rdata,
	output logic ce_n,
	output logic oe_n,
	output logic we_n,
	output logic [18:0] addr_out,
	output logic [7:0] dq_out,
	output logic dq_oe
);
	if (ACCESS_CYC < 1 || ACCESS_CYC > 15) begin : g_chk
		$error("ACCESS_CYC out of range");
	end
	// ---------------------------------------------------------------
	// Cycle phases
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		FCI_BC_IDLE, FCI_BC_SETUP, FCI_BC_STROBE, FCI_BC_HOLD,
		FCI_BC_ACCESS, FCI_BC_RECOVER
	} fci_bc_state_t;
	fci_bc_state_t state; // Current phase
	fci_bc_state_t next_state; // Following phase
	logic rd; // Latched direction
	logic [3:0] wait_cnt; // Read access counter
	wire access_end = (wait_cnt == 4'(ACCESS_CYC - 1));
	// Phase sequencing
	always_comb begin
		next_state = state;
		unique case (state)
			FCI_BC_IDLE: if (start) next_state = FCI_BC_SETUP;
			FCI_BC_SETUP: next_state = rd ? FCI_BC_ACCESS : FCI_BC_STROBE;
			FCI_BC_STROBE: next_state = FCI_BC_HOLD;
			FCI_BC_HOLD: next_state = FCI_BC_RECOVER;
			FCI_BC_ACCESS: if (access_end) next_state = FCI_BC_RECOVER;
			FCI_BC_RECOVER: next_state = FCI_BC_IDLE;
		endcase
	end
	// Decoded pin levels for the coming phase
	wire next_ce = next_state inside {FCI_BC_SETUP, FCI_BC_STROBE,
		FCI_BC_HOLD, FCI_BC_ACCESS};
	wire next_drive = next_state inside {FCI_BC_STROBE, FCI_BC_HOLD};
	// State, latches and counter
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= FCI_BC_IDLE;
			rd <= 1'b0;
			addr_out <= '0;
			dq_out <= 8'h00;
			wait_cnt <= 4'h0;
		end else begin
			state <= next_state;
			wait_cnt <= (state == FCI_BC_ACCESS) ? wait_cnt + 4'h1 : 4'h0;
			if (state == FCI_BC_IDLE && start) begin
				rd <= is_read;
				addr_out <= addr;
				dq_out <= wdata;
			end
		end
	end
	// Registered pins: address before strobe, data held past strobe rise
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ce_n <= 1'b1;
			oe_n <= 1'b1;
			we_n <= 1'b1;
			dq_oe <= 1'b0;
			done <= 1'b0;
			rdata <= 8'h00;
		end else begin
			ce_n <= !next_ce;
			oe_n <= !(next_state == FCI_BC_ACCESS);
			we_n <= !(next_state == FCI_BC_STROBE);
			dq_oe <= next_drive;
			done <= (state == FCI_BC_RECOVER);
			if (state == FCI_BC_ACCESS && access_end) rdata <= dq_in;
		end
	end
endmodule
`default_nettype wire

// file: fci_host.sv
// Host controller that issues flash command sequences on the pins.
// Assumes a byte-wide flash wired to address_lines and byte_lines.
`default_nettype none
// Behaviour
// RULE1: Device drops broken sequences; host sends whole ones
// RULE2: Reset as F0, or unlock pair then F0
// RULE3: Wait abort time after any reset
// RULE4: Auto select via unlock pair then 90
// RULE5: Auto select A1A0=00 reads maker code
// RULE6: Auto select A1A0=01 reads device code
// RULE7: A1A0=10 with block reads protection
// RULE8: Program: unlock pair, A0, then target byte
// RULE9: Protected target makes device ignore program
// RULE10: Issue nothing while program runs
// RULE11: Success returns read mode; failure needs reset
// RULE12: Program only clears bits; ones need erase
// RULE13: Bypass via unlock pair then 20
// RULE14: Bypass program A0+byte; exit 90 then 00
// RULE15: Chip erase is six writes ending 10
// RULE16: Block erase ends 30; add within window
// RULE17: B0 suspends erase, 30 resumes it
// RULE18: Command addresses use low eleven bits only
// RULE19: Address before strobe, data held past it
// RULE20: Drive byte lines only when output disabled
module fci_host #(
	parameter int ACCESS_CYC = fci_pkg::READ_ACCESS_CYC
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic cmd_valid,
	input wire fci_pkg::fci_op_t cmd_op,
	input wire logic [18:0] cmd_addr,
	input wire logic [7:0] cmd_data,
	output logic cmd_ready,
	output logic cmd_refused,
	output logic [7:0] rd_data,
	output logic rd_valid,
	output fci_pkg::fci_mode_t mode,
	output logic [18:0] address_lines,
	output logic [7:0] byte_lines_out,
	output logic byte_lines_oe,
	input wire logic [7:0] byte_lines_in,
	output logic chip_en_n,
	output logic out_en_n,
	output logic wr_en_n
);
	// ---------------------------------------------------------------
	// Reset release
	// ---------------------------------------------------------------
	logic rst_meta; // First stage
	logic rst_n; // Synchronised reset
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end
	// ---------------------------------------------------------------
	// Sequence table: {last, address, data} per step
	// ---------------------------------------------------------------
	function automatic logic [27:0] step_word(fci_pkg::fci_op_t op,
		logic [2:0] st, logic [18:0] a, logic [7:0] d);
		logic [18:0] u1;
		logic [18:0] u2;
		logic [26:0] pre;
		logic [26:0] pre2;
		u1 = {8'h00, fci_pkg::ADDR_UNLOCK1}; // see RULE18
		u2 = {8'h00, fci_pkg::ADDR_UNLOCK2};
		pre = (st == 3'h0) ? {u1, fci_pkg::DAT_UNLOCK1}
			: {u2, fci_pkg::DAT_UNLOCK2};
		pre2 = (st == 3'h3) ? {u1, fci_pkg::DAT_UNLOCK1}
			: {u2, fci_pkg::DAT_UNLOCK2};
		unique case (op)
			fci_pkg::FCI_OP_READ: step_word = {1'b1, a, 8'h00};
			fci_pkg::FCI_OP_RESET1: // see RULE2
				step_word = {1'b1, 19'h0, fci_pkg::CMD_RESET};
			fci_pkg::FCI_OP_RESET3:
				step_word = (st < 3'h2) ? {1'b0, pre}
					: {1'b1, 19'h0, fci_pkg::CMD_RESET};
			fci_pkg::FCI_OP_AUTOSEL: // see RULE4
				step_word = (st < 3'h2) ? {1'b0, pre}
					: {1'b1, u1, fci_pkg::CMD_AUTOSEL};
			fci_pkg::FCI_OP_PROGRAM: // see RULE8
				step_word = (st < 3'h2) ? {1'b0, pre}
					: (st == 3'h2) ? {1'b0, u1, fci_pkg::CMD_PROGRAM}
					: {1'b1, a, d};
			fci_pkg::FCI_OP_BYPASS: // see RULE13
				step_word = (st < 3'h2) ? {1'b0, pre}
					: {1'b1, u1, fci_pkg::CMD_BYPASS};
			fci_pkg::FCI_OP_BYPASS_PROG: // see RULE14
				step_word = (st == 3'h0)
					? {1'b0, 19'h0, fci_pkg::CMD_PROGRAM} : {1'b1, a, d};
			fci_pkg::FCI_OP_BYPASS_RESET:
				step_word = (st == 3'h0)
					? {1'b0, 19'h0, fci_pkg::CMD_AUTOSEL}
					: {1'b1, 19'h0, fci_pkg::CMD_BYPASS_EXIT};
			fci_pkg::FCI_OP_CHIP_ERASE, fci_pkg::FCI_OP_BLOCK_ERASE:
				// see RULE15 see RULE16
				step_word = (st < 3'h2) ? {1'b0, pre}
					: (st == 3'h2) ? {1'b0, u1, fci_pkg::CMD_ERASE_SETUP}
					: (st < 3'h5) ? {1'b0, pre2}
					: (op == fci_pkg::FCI_OP_CHIP_ERASE)
					? {1'b1, u1, fci_pkg::CMD_CHIP_ERASE}
					: {1'b1, a, fci_pkg::CMD_BLOCK_ERASE};
			fci_pkg::FCI_OP_BLOCK_ADD:
				step_word = {1'b1, a, fci_pkg::CMD_BLOCK_ERASE};
			fci_pkg::FCI_OP_SUSPEND: // see RULE17
				step_word = {1'b1, 19'h0, fci_pkg::CMD_SUSPEND};
			fci_pkg::FCI_OP_RESUME:
				step_word = {1'b1, 19'h0, fci_pkg::CMD_RESUME};
			default: step_word = {1'b1, 19'h0, fci_pkg::CMD_RESET};
		endcase
	endfunction
	// ---------------------------------------------------------------
	// Sequencer state
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {FCI_S_IDLE, FCI_S_BUS, FCI_S_HOLD} fci_seq_t;
	fci_seq_t state; // Sequencer phase
	fci_seq_t next_state; // Following phase
	fci_pkg::fci_op_t cur_op; // Operation in flight
	logic [18:0] cur_addr; // Target address
	logic [7:0] cur_data; // Target byte
	logic [2:0] step; // Write index within sequence
	logic bus_start; // Start pulse to engine
	logic [11:0] hold_cnt; // Settle wait after sequence
	logic [9:0] window_cnt; // Block-add window remaining
	logic bus_done; // Engine finished a cycle
	logic [7:0] bus_rdata; // Engine read byte
	// Decode of the current step and of the incoming request
	wire [27:0] word = step_word(cur_op, step, cur_addr, cur_data);
	wire step_last = word[27];
	wire taken = cmd_valid && cmd_ready;
	wire in_bypass = (mode == fci_pkg::FCI_MODE_BYPASS);
	wire bypass_op = cmd_op inside {fci_pkg::FCI_OP_BYPASS_PROG,
		fci_pkg::FCI_OP_BYPASS_RESET};
	wire bypass_ok = bypass_op || cmd_op inside {fci_pkg::FCI_OP_READ,
		fci_pkg::FCI_OP_RESET1};
	// Only commands the device accepts in the tracked mode go out
	wire refuse = in_bypass ? !bypass_ok // see RULE13
		: (bypass_op || (cmd_op == fci_pkg::FCI_OP_BLOCK_ADD
		&& window_cnt == 10'h0)); // see RULE16
	wire seq_end = (state == FCI_S_BUS) && bus_done && step_last;
	wire is_reset = cur_op inside {fci_pkg::FCI_OP_RESET1,
		fci_pkg::FCI_OP_RESET3};
	wire is_prog = cur_op inside {fci_pkg::FCI_OP_PROGRAM,
		fci_pkg::FCI_OP_BYPASS_PROG};
	wire opens_window = cur_op inside {fci_pkg::FCI_OP_BLOCK_ERASE,
		fci_pkg::FCI_OP_BLOCK_ADD};
	// Settle time after the last write of a sequence
	wire [11:0] hold_len = is_reset ? 12'(fci_pkg::ABORT_CYC) // see RULE3
		: is_prog ? 12'(fci_pkg::PROGRAM_CYC) // see RULE10
		: (cur_op == fci_pkg::FCI_OP_SUSPEND)
		? 12'(fci_pkg::SUSPEND_CYC) : 12'h0;
	// Mode that the device takes on when a sequence completes
	wire fci_pkg::fci_mode_t next_mode =
		(cur_op == fci_pkg::FCI_OP_AUTOSEL) ? fci_pkg::FCI_MODE_AUTOSEL
		: (cur_op == fci_pkg::FCI_OP_BYPASS) ? fci_pkg::FCI_MODE_BYPASS
		: (cur_op == fci_pkg::FCI_OP_READ || in_bypass
		&& cur_op != fci_pkg::FCI_OP_BYPASS_RESET)
		? mode : fci_pkg::FCI_MODE_READ; // see RULE14 see RULE11
	// Phase sequencing; sequences are never cut short
	always_comb begin
		next_state = state;
		unique case (state)
			FCI_S_IDLE: if (taken && !refuse) next_state = FCI_S_BUS;
			FCI_S_BUS: if (seq_end) next_state = (hold_len == 12'h0)
				? FCI_S_IDLE : FCI_S_HOLD; // see RULE1
			FCI_S_HOLD: if (hold_cnt == 12'h1) next_state = FCI_S_IDLE;
		endcase
	end
	// Request capture and step advance
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state <= FCI_S_IDLE;
			cur_op <= fci_pkg::FCI_OP_READ;
			cur_addr <= '0;
			cur_data <= 8'h00;
			step <= 3'h0;
			bus_start <= 1'b0;
		end else begin
			state <= next_state;
			bus_start <= (state == FCI_S_IDLE && taken && !refuse)
				|| (state == FCI_S_BUS && bus_done && !step_last);
			if (state == FCI_S_IDLE && taken) begin
				cur_op <= cmd_op;
				cur_addr <= cmd_addr;
				cur_data <= cmd_data;
				step <= 3'h0;
			end else if (state == FCI_S_BUS && bus_done) begin
				step <= step + 3'h1;
			end
		end
	end
	// Counters, tracked mode and user-side answers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			hold_cnt <= 12'h0;
			window_cnt <= 10'h0;
			mode <= fci_pkg::FCI_MODE_READ;
			cmd_ready <= 1'b0;
			cmd_refused <= 1'b0;
			rd_valid <= 1'b0;
			rd_data <= 8'h00;
		end else begin
			hold_cnt <= seq_end ? hold_len
				: (hold_cnt != 12'h0) ? hold_cnt - 12'h1 : 12'h0;
			window_cnt <= (seq_end && opens_window)
				? 10'(fci_pkg::WINDOW_CYC)
				: (window_cnt != 10'h0) ? window_cnt - 10'h1 : 10'h0;
			if (seq_end) mode <= next_mode;
			cmd_ready <= (next_state == FCI_S_IDLE);
			cmd_refused <= taken && refuse;
			rd_valid <= seq_end && cur_op == fci_pkg::FCI_OP_READ;
			if (seq_end && cur_op == fci_pkg::FCI_OP_READ)
				rd_data <= bus_rdata; // see RULE5 see RULE6 see RULE7
		end
	end
	// ---------------------------------------------------------------
	// Pin engine
	// ---------------------------------------------------------------
	fci_bus_cycle #(.ACCESS_CYC(ACCESS_CYC)) u_bus (
		.clk(mclk),
		.rst_n(rst_n),
		.start(bus_start),
		.is_read(cur_op == fci_pkg::FCI_OP_READ),
		.addr(word[26:8]),
		.wdata(word[7:0]),
		.dq_in(byte_lines_in),
		.done(bus_done),
		.rdata(bus_rdata),
		.ce_n(chip_en_n),
		.oe_n(out_en_n),
		.we_n(wr_en_n),
		.addr_out(address_lines),
		.dq_out(byte_lines_out),
		.dq_oe(byte_lines_oe)
	);
	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	refuse_bypass_a: assert property ( // see RULE14
		taken && !in_bypass && cmd_op == fci_pkg::FCI_OP_BYPASS_PROG
		|=> cmd_refused && cmd_ready && state == FCI_S_IDLE)
		else $error("bypass program sent outside bypass");
	bypass_only_a: assert property ( // see RULE13
		taken && in_bypass && cmd_op == fci_pkg::FCI_OP_AUTOSEL
		|=> cmd_refused) else $error("foreign command sent in bypass");
	bypass_enter_a: assert property ( // see RULE13
		seq_end && cur_op == fci_pkg::FCI_OP_BYPASS
		|=> mode == fci_pkg::FCI_MODE_BYPASS) else $error("no bypass");
	window_shut_a: assert property ( // see RULE16
		taken && cmd_op == fci_pkg::FCI_OP_BLOCK_ADD && window_cnt == 10'h0
		|=> cmd_refused) else $error("block add after window");
	reset_wait_a: assert property ( // see RULE3
		seq_end && is_reset |=> !cmd_ready [*8])
		else $error("reset abort wait skipped");
	drive_exclusive_a: assert property ( // see RULE20
		byte_lines_oe |-> out_en_n && !chip_en_n)
		else $error("byte lines driven during read");
	addr_stable_a: assert property ( // see RULE19
		!wr_en_n |-> $stable(address_lines) && !chip_en_n)
		else $error("address moved during strobe");
	data_hold_a: assert property ( // see RULE19
		$rose(wr_en_n) |-> byte_lines_oe && $stable(byte_lines_out))
		else $error("data released before strobe rise");
	prog_len_a: assert property ( // see RULE8
		bus_start && cur_op == fci_pkg::FCI_OP_PROGRAM && step == 3'h3
		|-> word[7:0] == cur_data && step_last)
		else $error("program sequence malformed");
endmodule
`default_nettype wire

// file: fci_flash_model.sv
// Behavioural byte-wide flash device that answers the host's pin cycles.
// Assumes strobes are active low and the host drives data while writing.
`default_nettype none
module fci_flash_model #(
	parameter logic [7:0] PROT_MASK = 8'h80, // Block 7 protected
	parameter logic [7:0] MAKER_CODE = 8'h5c, // Arbitrary value
	parameter logic [7:0] DEV_CODE = 8'h3b, // Arbitrary value
	parameter logic [7:0] STAT = 8'ha5, // Status byte seen while busy
	parameter int PROG_NS = 150000, // Program busy time
	parameter int ABORT_NS = 5000 // Reset abort time after an error
) (
	input wire logic [18:0] address_lines,
	input wire logic [7:0] byte_lines_out,
	input wire logic byte_lines_oe,
	output logic [7:0] byte_lines_in,
	input wire logic chip_en_n,
	input wire logic out_en_n,
	input wire logic wr_en_n
);
	timeunit 1ns;
	timeprecision 100ps;
	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	logic [7:0] mem [int]; // Missing entries read as erased
	logic [18:0] lat_a; // Latched write address
	int seq = 0; // Position in a command sequence
	logic busy = 1'b0; // Program or abort in progress
	logic err = 1'b0; // Failed program awaiting reset
	fci_pkg::fci_mode_t md = fci_pkg::FCI_MODE_READ;
	logic [7:0] q; // Value a read would return
	logic [7:0] last = 8'h00; // Last driven byte
	wire logic strobe_n;
	wire logic rd_sel;
	assign strobe_n = chip_en_n | wr_en_n;
	assign rd_sel = !chip_en_n && !out_en_n && wr_en_n;
	// ---------------------------------------------------------------
	// Array operations
	// ---------------------------------------------------------------
	// Clears an error; reads give status during the abort
	task automatic clear();
		if (err) begin
			err = 1'b0;
			busy <= 1'b1;
			busy <= #ABORT_NS 1'b0;
		end
	endtask
	// Only clears bits; protected blocks are left alone
	task automatic prog(input logic [18:0] a, input logic [7:0] d);
		logic [7:0] old;
		old = mem.exists(int'(a)) ? mem[int'(a)] : 8'hff;
		if (PROT_MASK[a[18:16]]) return;
		if ((old & d) != d) begin
			err = 1'b1;
		end else begin
			mem[int'(a)] = d;
			busy <= 1'b1;
			busy <= #PROG_NS 1'b0;
		end
	endtask
	// Erases listed unprotected blocks at once
	task automatic erase(input logic [7:0] blks);
		int keys [$];
		foreach (mem[i]) begin
			if (blks[i[18:16]] && !PROT_MASK[i[18:16]]) keys.push_back(i);
		end
		foreach (keys[k]) mem.delete(keys[k]);
		seq = (blks == 8'hff) ? 0 : 6;
	endtask
	// ---------------------------------------------------------------
	// Command decoder
	// ---------------------------------------------------------------
	task automatic take(input logic [18:0] a, input logic [7:0] d);
		logic [10:0] c;
		c = a[10:0];
		if (busy) return;
		if (seq == 8) begin
			prog(a, d);
			seq = 0;
		end else if (md == fci_pkg::FCI_MODE_BYPASS) begin
			if (seq == 0 && d == 8'ha0) seq = 8;
			else if (seq == 0 && d == 8'h90) seq = 9;
			else if (seq == 9 && d == 8'h00) begin
				md = fci_pkg::FCI_MODE_READ;
				seq = 0;
			end else begin
				seq = 0;
				if (d == 8'hf0) clear();
			end
		end else if (d == 8'hf0) begin
			md = fci_pkg::FCI_MODE_READ;
			seq = 0;
			clear();
		end else if (seq == 0 && c == 11'h555 && d == 8'haa) seq = 1;
		else if (seq == 3 && c == 11'h555 && d == 8'haa) seq = 4;
		else if ((seq == 1 || seq == 4) && c == 11'h2aa && d == 8'h55) begin
			seq = seq + 1;
		end else if (seq == 2 && c == 11'h555) begin
			case (d)
				8'h90: md = fci_pkg::FCI_MODE_AUTOSEL;
				8'h20: md = fci_pkg::FCI_MODE_BYPASS;
				default: md = fci_pkg::FCI_MODE_READ;
			endcase
			seq = (d == 8'ha0) ? 8 : (d == 8'h80) ? 3 : 0;
		end else if (seq == 5 && c == 11'h555 && d == 8'h10) erase(8'hff);
		else if ((seq == 5 || seq == 6) && d == 8'h30) begin
			erase(8'h01 << a[18:16]);
		end else begin
			seq = 0;
			md = fci_pkg::FCI_MODE_READ;
		end
	endtask
	// Address on the later falling edge, data on the first rising
	always @(negedge strobe_n) lat_a = address_lines;
	always @(posedge strobe_n) begin
		if (byte_lines_oe === 1'b1) take(lat_a, byte_lines_out);
	end
	// ---------------------------------------------------------------
	// Read path; a released bus shows the inverse of the last byte
	// ---------------------------------------------------------------
	always @* begin
		if (busy || err) q = STAT;
		else if (md != fci_pkg::FCI_MODE_AUTOSEL) begin
			q = mem.exists(int'(address_lines)) ? mem[int'(address_lines)] : 8'hff;
		end else if (address_lines[1:0] == 2'b00) q = MAKER_CODE;
		else if (address_lines[1:0] == 2'b01) q = DEV_CODE;
		else q = {7'h00, PROT_MASK[address_lines[18:16]]};
		byte_lines_in = rd_sel ? q : ~last;
	end
	always @(negedge rd_sel) last = q;
endmodule
`default_nettype wire

// file: fci_host_tb.sv
// Self-checking bench: the flash command host driving a flash model.
// Assumes fci_pkg, fci_host and fci_flash_model are compiled first.
`default_nettype none
module fci_host_tb;
	timeunit 1ns;
	timeprecision 100ps;
	// ---------------------------------------------------------------
	// Signals and bookkeeping
	// ---------------------------------------------------------------
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic cmd_valid = 1'b0;
	fci_pkg::fci_op_t cmd_op = fci_pkg::FCI_OP_READ;
	logic [18:0] cmd_addr = 19'h00000;
	logic [7:0] cmd_data = 8'h00;
	logic cmd_ready, cmd_refused, rd_valid, byte_lines_oe;
	logic chip_en_n, out_en_n, wr_en_n;
	logic [7:0] rd_data, byte_lines_out, byte_lines_in;
	logic [18:0] address_lines;
	fci_pkg::fci_mode_t mode;
	logic [8:0] exp_q [$]; // Expected results: refusal flag, byte
	logic [18:0] pa [4]; // Programmed addresses
	logic [7:0] pv [4]; // Programmed values
	logic [7:0] rnd = 8'h2f; // Random state
	int n_errors = 0;
	int num_checks = 0;
	fci_host i_dut (.mclk(mclk), .arst_n(arst_n), .cmd_valid(cmd_valid),
		.cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
		.cmd_ready(cmd_ready), .cmd_refused(cmd_refused), .rd_data(rd_data),
		.rd_valid(rd_valid), .mode(mode), .address_lines(address_lines),
		.byte_lines_out(byte_lines_out), .byte_lines_oe(byte_lines_oe),
		.byte_lines_in(byte_lines_in), .chip_en_n(chip_en_n),
		.out_en_n(out_en_n), .wr_en_n(wr_en_n));
	fci_flash_model i_flash (.address_lines(address_lines),
		.byte_lines_out(byte_lines_out), .byte_lines_oe(byte_lines_oe),
		.byte_lines_in(byte_lines_in), .chip_en_n(chip_en_n),
		.out_en_n(out_en_n), .wr_en_n(wr_en_n));
	// 20 MHz clock
	initial begin
		forever #25 mclk = ~mclk;
	end
	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic chk_res(input logic [8:0] e, input logic [8:0] g);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic chk_mode(input fci_pkg::fci_mode_t e);
		wait_ready();
		num_checks++;
		if (mode !== e) begin
			n_errors++;
			$display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, mode);
		end
	endtask
	// Bounded wait, entered and left at a falling edge
	task automatic wait_ready();
		int n;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 9000) begin
			@(negedge mclk);
			n++;
		end
		if (n >= 9000) n_errors++;
	endtask
	// One request, held until the edge that takes it
	task automatic op(input fci_pkg::fci_op_t o, input logic [18:0] a,
		input logic [7:0] d);
		wait_ready();
		cmd_valid = 1'b1;
		cmd_op = o;
		cmd_addr = a;
		cmd_data = d;
		@(negedge mclk);
		cmd_valid = 1'b0;
		@(negedge mclk);
	endtask
	task automatic rd(input logic [18:0] a, input logic [7:0] e);
		exp_q.push_back({1'b0, e});
		op(fci_pkg::FCI_OP_READ, a, 8'h00);
	endtask
	task automatic refuse(input fci_pkg::fci_op_t o, input logic [18:0] a);
		exp_q.push_back(9'h100);
		op(o, a, 8'h00);
	endtask
	task automatic note(input string s);
		$display("test %s done", s);
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Each result takes the oldest expectation
	always @(negedge mclk) begin
		if (rd_valid === 1'b1 || cmd_refused === 1'b1) begin
			if (exp_q.size() == 0) exp_q.push_back(9'h1ff);
			chk_res(exp_q.pop_front(), (cmd_refused === 1'b1) ? 9'h100 :
				{1'b0, rd_data});
		end
	end
	// Watchdog: all tests need about 35000 cycles
	initial begin
		repeat (60000) @(posedge mclk);
		n_errors++;
		summarize();
	end
	// ---------------------------------------------------------------
	// Tests
	// ---------------------------------------------------------------
	initial begin
		repeat (10) @(negedge mclk);
		arst_n = 1'b1;
		rd(19'h01234, 8'hff);
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			pv[i] = rnd & 8'h7f;
			pa[i] = {i[2:0], 8'h3c, rnd};
			op(fci_pkg::FCI_OP_PROGRAM, pa[i], pv[i]);
			rd(pa[i], pv[i]);
		end
		note("program");
		op(fci_pkg::FCI_OP_PROGRAM, pa[0], 8'hff);
		rd(pa[0], 8'ha5);
		op(fci_pkg::FCI_OP_RESET1, 19'h00000, 8'h00);
		rd(pa[0], pv[0]);
		op(fci_pkg::FCI_OP_PROGRAM, pa[0], 8'hff);
		op(fci_pkg::FCI_OP_RESET3, 19'h00000, 8'h00);
		rd(pa[0], pv[0]);
		op(fci_pkg::FCI_OP_PROGRAM, 19'h70040, 8'h12);
		rd(19'h70040, 8'hff);
		note("errors");
		op(fci_pkg::FCI_OP_AUTOSEL, 19'h00000, 8'h00);
		rd(19'h5fffc, 8'h5c);
		rd(19'h2aaa1, 8'h3b);
		rd(19'h70002, 8'h01);
		rd(19'h1fff2, 8'h00);
		chk_mode(fci_pkg::FCI_MODE_AUTOSEL);
		op(fci_pkg::FCI_OP_RESET1, 19'h00000, 8'h00);
		chk_mode(fci_pkg::FCI_MODE_READ);
		note("auto select");
		op(fci_pkg::FCI_OP_BYPASS, 19'h00000, 8'h00);
		chk_mode(fci_pkg::FCI_MODE_BYPASS);
		refuse(fci_pkg::FCI_OP_PROGRAM, pa[1]);
		refuse(fci_pkg::FCI_OP_AUTOSEL, 19'h00000);
		rd(pa[1], pv[1]);
		rnd = lfsr(rnd);
		op(fci_pkg::FCI_OP_BYPASS_PROG, 19'h62345, rnd & 8'h7f);
		rd(19'h62345, rnd & 8'h7f);
		op(fci_pkg::FCI_OP_BYPASS_RESET, 19'h00000, 8'h00);
		chk_mode(fci_pkg::FCI_MODE_READ);
		refuse(fci_pkg::FCI_OP_BYPASS_PROG, pa[1]);
		note("bypass");
		op(fci_pkg::FCI_OP_BLOCK_ERASE, pa[1], 8'h00);
		op(fci_pkg::FCI_OP_BLOCK_ADD, pa[2], 8'h00);
		rd(pa[1], 8'hff);
		rd(pa[2], 8'hff);
		rd(pa[3], pv[3]);
		repeat (1100) @(negedge mclk);
		refuse(fci_pkg::FCI_OP_BLOCK_ADD, pa[3]);
		op(fci_pkg::FCI_OP_SUSPEND, 19'h00000, 8'h00);
		op(fci_pkg::FCI_OP_RESUME, 19'h00000, 8'h00);
		chk_mode(fci_pkg::FCI_MODE_READ);
		op(fci_pkg::FCI_OP_CHIP_ERASE, 19'h00000, 8'h00);
		rd(pa[3], 8'hff);
		rd(pa[0], 8'hff);
		note("erase");
		wait_ready();
		repeat (20) @(negedge mclk);
		summarize();
	end
endmodule
`default_nettype wire
